// file: rtl/time_stamp_pkg.sv
// Constants shared by the event time stamp counter and its divider
package time_stamp_pkg;
  localparam int MASTER_CLOCK_HZ = 4194304;
  localparam int TICK_HZ = 8192;
  localparam int TICK_DIVIDE = MASTER_CLOCK_HZ / TICK_HZ;
  localparam int TIME_WIDTH = 16;
  localparam logic [TIME_WIDTH-1:0] TIME_RESET_VALUE = 16'h0000;
  localparam logic [TIME_WIDTH-1:0] TIME_STEP = 16'h0001;
endpackage : time_stamp_pkg

// file: rtl/edge_rise_detect.sv
// Synchroniser with rising edge detection for one pin input
`timescale 1ns/100ps
module edge_rise_detect (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops before any logic; the first is read by the second only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign level_out = sync2_reg;
  assign rise_out = sync2_reg & ~prev_reg;
endmodule : edge_rise_detect

// file: rtl/event_time_stamp_counter.sv
// Event time stamp counter: fine time and reset count words
`timescale 1ns/100ps
module event_time_stamp_counter
  import time_stamp_pkg::*;
#(
  parameter int WIDTH = TIME_WIDTH,
  parameter int DIVIDE = TICK_DIVIDE
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic MASTER_CLOCK,
  input wire logic ONE_HZ_PULSE,
  input wire logic EIGHTH_HZ_GATE,
  input wire logic EVENT_STROBE,
  output logic [WIDTH-1:0] FINE_TIME,
  output logic [WIDTH-1:0] RESET_COUNT,
  output logic TICK,
  output logic STAMP_VALID,
  output logic [WIDTH-1:0] STAMP_FINE,
  output logic [WIDTH-1:0] STAMP_RESETS
);
  localparam int DIV_W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIVIDE - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
  localparam logic [WIDTH-1:0] ZERO_W = WIDTH'(TIME_RESET_VALUE);
  localparam logic [WIDTH-1:0] STEP_W = WIDTH'(TIME_STEP);

  // Synchronised pin events
  logic master_rise;
  logic pulse_rise;
  logic gate_level;
  logic gated_reset;
  logic tick_due;

  // Tick divider
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic tick_reg;
  logic tick_next;

  // Time words
  logic [WIDTH-1:0] fine_reg;
  logic [WIDTH-1:0] fine_next;
  logic [WIDTH-1:0] resets_reg;
  logic [WIDTH-1:0] resets_next;

  // Event stamp
  logic stamp_valid_reg;
  logic stamp_valid_next;
  logic [WIDTH-1:0] stamp_fine_reg;
  logic [WIDTH-1:0] stamp_fine_next;
  logic [WIDTH-1:0] stamp_resets_reg;
  logic [WIDTH-1:0] stamp_resets_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin inputs; master clock is sampled, so CLK must exceed twice its rate
  edge_rise_detect master_sync (
    .clk(CLK),
    .reset(RESET),
    .pin_in(MASTER_CLOCK),
    .level_out(),
    .rise_out(master_rise)
  );

  edge_rise_detect pulse_sync (
    .clk(CLK),
    .reset(RESET),
    .pin_in(ONE_HZ_PULSE),
    .level_out(),
    .rise_out(pulse_rise)
  );

  edge_rise_detect gate_sync (
    .clk(CLK),
    .reset(RESET),
    .pin_in(EIGHTH_HZ_GATE),
    .level_out(gate_level),
    .rise_out()
  );

  // Reset gating: only a 1 Hz edge that meets the gate high resets the
  // time base; the gate is a level, so its own edges never count
  // A pulse edge with the gate low is ignored and leaves both words alone
  assign gated_reset = pulse_rise & gate_level;

  ////////////////////////////////////////////////////////////////////////////
  // Divider next state; a gated reset restarts it so every 8 s period
  // begins on a whole tick, and master edges in that cycle are dropped
  assign tick_due = master_rise & (div_reg == DIV_LAST);

  always_comb begin
    div_next = div_reg;
    if (gated_reset) begin
      div_next = DIV_ZERO;
    end else if (tick_due) begin
      div_next = DIV_ZERO;
    end else if (master_rise) begin
      div_next = div_reg + DIV_ONE;
    end
  end

  // Divider register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_reg <= DIV_ZERO;
    end else begin
      div_reg <= div_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick strobe, one cycle wide; a coincident gated reset swallows it so
  // the first tick of a period always comes a full division later
  assign tick_next = tick_due & ~gated_reset;

  // Tick register; it also leaves the block so users can pace on it
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fine time next value; the reset wins over a coincident tick, which
  // would otherwise leave the new period starting at one
  always_comb begin
    fine_next = fine_reg;
    if (gated_reset) begin
      fine_next = ZERO_W;
    end else if (tick_reg) begin
      fine_next = fine_reg + STEP_W;
    end
  end

  // Fine time register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      fine_reg <= ZERO_W;
    end else begin
      fine_reg <= fine_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset count next value; it wraps modulo 2**WIDTH, so whoever reads it
  // must unwrap it against its own slower time base
  always_comb begin
    resets_next = resets_reg;
    if (gated_reset) begin
      resets_next = resets_reg + STEP_W;
    end
  end

  // Reset count register; moves in the same edge as the fine time clear
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      resets_reg <= ZERO_W;
    end else begin
      resets_reg <= resets_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stamp strobe follows the event by exactly one cycle
  // Back-to-back strobes are fine; each one gives its own valid cycle
  assign stamp_valid_next = EVENT_STROBE;

  // Stamp valid register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stamp_valid_reg <= 1'b0;
    end else begin
      stamp_valid_reg <= stamp_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stamp words next value; both come from registers on one edge, so a
  // stamp never pairs a fine time of one period with the count of the next
  // Without a strobe the last stamp stands for as long as needed
  always_comb begin
    stamp_fine_next = stamp_fine_reg;
    stamp_resets_next = stamp_resets_reg;
    if (EVENT_STROBE) begin
      stamp_fine_next = fine_reg;
      stamp_resets_next = resets_reg;
    end
  end

  // Stamp fine time register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stamp_fine_reg <= ZERO_W;
    end else begin
      stamp_fine_reg <= stamp_fine_next;
    end
  end

  // Stamp reset count register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stamp_resets_reg <= ZERO_W;
    end else begin
      stamp_resets_reg <= stamp_resets_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from registers; the partner latches its onboard time
  // on the same gated pulse, so stamps and its readings can be correlated
  // Nothing here is combinational, so downstream timing sees clean flops
  assign FINE_TIME = fine_reg;
  assign RESET_COUNT = resets_reg;
  assign TICK = tick_reg;
  assign STAMP_VALID = stamp_valid_reg;
  assign STAMP_FINE = stamp_fine_reg;
  assign STAMP_RESETS = stamp_resets_reg;
endmodule : event_time_stamp_counter

// file: test/time_base_source.sv
// Partner: master clock and pulse pins of the processing unit
`timescale 1ns/100ps
module time_base_source (
  output logic master_clock,
  output logic one_hz_pulse,
  output logic eighth_hz_gate
);
  int latches;
  // Master clock runs free; pins start low
  initial begin
    {master_clock, one_hz_pulse, eighth_hz_gate, latches} = '0;
    forever #119.2 master_clock = ~master_clock;
  end
  // Pulse locked to master phase, so resets stay aligned
  task automatic pulse(input bit g);
    eighth_hz_gate = g;
    @(negedge master_clock) one_hz_pulse = 1;
    if (g) latches++; // Onboard time frozen here
    repeat (2) @(negedge master_clock);
    {one_hz_pulse, eighth_hz_gate} = '0;
  endtask : pulse
endmodule : time_base_source

// file: test/stamp_sva.sv
// Checker for the time stamp counter outputs
`timescale 1ns/100ps
module stamp_sva #(parameter int WIDTH = 16) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic EVENT_STROBE,
  input wire logic TICK,
  input wire logic STAMP_VALID,
  input wire logic [WIDTH-1:0] FINE_TIME,
  input wire logic [WIDTH-1:0] RESET_COUNT,
  input wire logic [WIDTH-1:0] STAMP_FINE,
  input wire logic [WIDTH-1:0] STAMP_RESETS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Tick and fine time; a clear without a tick before it needs a counted reset
  a_tick_single:
    assert property (TICK |=> !TICK) else $error("tick too long");
  a_tick_step:
    assert property (TICK |=> FINE_TIME == $past(FINE_TIME) + 1'b1 || $changed(RESET_COUNT))
    else $error("fine step");
  a_fine_cause:
    assert property ($changed(FINE_TIME) |-> $past(TICK) || $changed(RESET_COUNT))
    else $error("fine moved");
  // Reset pairing and event stamps
  a_reset_pair:
    assert property ($changed(RESET_COUNT) |-> RESET_COUNT == $past(RESET_COUNT) + 1'b1
      && FINE_TIME == '0) else $error("reset pair");
  a_clear_counted:
    assert property ($changed(FINE_TIME) && FINE_TIME == '0 && !$past(TICK)
      |-> $changed(RESET_COUNT)) else $error("clear uncounted");
  a_stamp_words:
    assert property (EVENT_STROBE |=> STAMP_VALID && STAMP_FINE == $past(FINE_TIME)
      && STAMP_RESETS == $past(RESET_COUNT)) else $error("stamp words");
  a_stamp_hold:
    assert property (!EVENT_STROBE |=> $stable(STAMP_FINE) && $stable(STAMP_RESETS))
    else $error("stamp drift");
  a_valid_cause:
    assert property (STAMP_VALID |-> $past(EVENT_STROBE)) else $error("stray valid");
  // Main scenarios
  c_tick: cover property (TICK);
  c_reset: cover property ($changed(RESET_COUNT));
  c_strobes: cover property (EVENT_STROBE ##1 EVENT_STROBE);
endmodule : stamp_sva
bind event_time_stamp_counter stamp_sva #(.WIDTH(WIDTH)) stamp_sva_i (.CLK(CLK),
  .RESET(RESET), .EVENT_STROBE(EVENT_STROBE), .TICK(TICK), .STAMP_VALID(STAMP_VALID),
  .FINE_TIME(FINE_TIME), .RESET_COUNT(RESET_COUNT), .STAMP_FINE(STAMP_FINE),
  .STAMP_RESETS(STAMP_RESETS));

// file: test/event_time_stamp_counter_tb.sv
// Self-checking bench for the event time stamp counter
`timescale 1ns/100ps
module event_time_stamp_counter_tb;
  localparam int DIV = 4;
  localparam int EDGES = 10;
  logic clk, reset, strobe, valid, tick, mclk, pulse, gate, pulse_d;
  logic [15:0] fine, count, s_fine, s_count, exp_count;
  int bad_count, checks, ticks;
  // Divider shortened to DIV master edges a tick
  event_time_stamp_counter #(.DIVIDE(DIV)) event_time_stamp_counter_i (.CLK(clk),
    .RESET(reset), .MASTER_CLOCK(mclk), .ONE_HZ_PULSE(pulse), .EIGHTH_HZ_GATE(gate),
    .EVENT_STROBE(strobe), .FINE_TIME(fine), .RESET_COUNT(count), .TICK(tick),
    .STAMP_VALID(valid), .STAMP_FINE(s_fine), .STAMP_RESETS(s_count));
  time_base_source time_base_source_i (.master_clock(mclk), .one_hz_pulse(pulse),
    .eighth_hz_gate(gate));
  task automatic check(input string n, input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Expected words: one tick per DIV master edges, one count per gated pulse
  function automatic logic [15:0] fine_after(input int edges);
    return 16'(edges / DIV);
  endfunction : fine_after
  function automatic logic [15:0] count_after(input logic [15:0] c, input bit g);
    return c + 16'(g);
  endfunction : count_after
  // Ticks seen since the latest 1 Hz pulse edge
  always @(posedge clk) begin
    pulse_d <= pulse;
    if (pulse === 1'b1 && pulse_d === 1'b0) ticks <= 0;
    else if (tick === 1'b1) ticks <= ticks + 1;
  end
  task automatic close_out;
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // 125 MHz clock; watchdog well past the run length
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    #100us;
    bad_count++;
    close_out();
  end
  // Gate low first, then high, then random; EDGES master edges follow each pulse
  initial begin
    {strobe, bad_count, checks, exp_count} = '0;
    reset = 1;
    void'($urandom(34436));
    repeat (6) @(posedge clk);
    @(negedge clk) reset = 0;
    for (int i = 0; i < 8; i++) begin
      bit g;
      bit r;
      g = (i < 2) ? i[0] : 1'($urandom);
      r = 1'($urandom);
      time_base_source_i.pulse(g);
      exp_count = count_after(exp_count, g);
      repeat (EDGES - 2) @(negedge mclk);
      @(negedge clk) strobe = 1;
      check("resets", count, exp_count);
      check("latches", count, 16'(time_base_source_i.latches));
      if (g) check("fine", fine, fine_after(EDGES));
      if (g) check("ticks", 16'(ticks), fine_after(EDGES));
      @(negedge clk) strobe = r;
      check("valid", 16'(valid), 16'h0001);
      @(negedge clk) strobe = 0;
      check("valid again", 16'(valid), 16'(r));
      check("stamp resets", s_count, exp_count);
      if (g) check("stamp fine", s_fine, fine_after(EDGES));
    end
    close_out();
  end
endmodule : event_time_stamp_counter_tb
